//--- hw/rrs_alu.sv
// Combinational rotate and subtract-with-borrow datapath
`timescale 1ns/1ps
`default_nettype none
module rrs_alu
	import rrs_pkg::*;
(
	// Operation and operands
	input wire rrs_op_t op_i,
	input wire logic [DATA_W-1:0] src_i,
	input wire logic [DATA_W-1:0] work_i,
	input wire logic carry_i,
	// Results
	output logic [DATA_W-1:0] res_o,
	output logic carry_o,
	output logic half_o,
	output logic zero_o
);
	logic [DATA_W:0] sum;
	logic [NIBBLE_W:0] low_sum;

	always_comb begin
		sum = {1'b0, src_i} + {1'b0, ~work_i} + {{DATA_W{1'b0}}, carry_i};
		low_sum = {1'b0, src_i[NIBBLE_W-1:0]} + {1'b0, ~work_i[NIBBLE_W-1:0]}
			+ {{NIBBLE_W{1'b0}}, carry_i};
		res_o = src_i;
		carry_o = carry_i;
		half_o = low_sum[NIBBLE_W];
		unique case (op_i)
			RRS_OP_ROTATE_LEFT: begin
				res_o = {src_i[DATA_W-2:0], carry_i};
				carry_o = src_i[DATA_W-1];
			end
			RRS_OP_ROTATE_RIGHT: begin
				res_o = {carry_i, src_i[DATA_W-1:1]};
				carry_o = src_i[0];
			end
			RRS_OP_SUBTRACT_WITH_BORROW: begin
				res_o = sum[DATA_W-1:0];
				carry_o = sum[DATA_W];
			end
			default: begin
				res_o = src_i;
				carry_o = carry_i;
			end
		endcase
		zero_o = (res_o == '0);
	end
endmodule
`default_nettype wire

//--- hw/rrs_exec.sv
// Execution unit for return, rotate-through-carry and subtract-with-borrow
//
// Function
// - Return reloads PC, pops stack, two cycles
// - Rotate left: carry in bit 0, bit 7 out
// - Destination bit picks working or file register
// - Rotate left changes only carry, one cycle
// - Rotate right: carry in bit 7, bit 0 out
// - Rotate right changes only carry, one cycle
// - Subtract: file plus inverted working plus carry
// - Literal return loads working, sets irq enable
`timescale 1ns/1ps
`default_nettype none
module rrs_exec
	import rrs_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Instruction issue, taken when busy_o is low
	input wire logic start_i,
	input wire rrs_op_t op_i,
	input wire logic dest_sel_i,
	input wire logic [DATA_W-1:0] file_data_i,
	input wire logic [DATA_W-1:0] literal_i,
	// Stack top and depth from the stack block
	input wire logic [PC_W-1:0] stack_top_i,
	input wire logic [DEPTH_W-1:0] stack_depth_i,
	// Flags in from the status register
	input wire logic carry_i,
	input wire logic half_carry_flag_i,
	input wire logic zero_i,
	// Architectural results
	output logic [DATA_W-1:0] working_register_o,
	output logic [DATA_W-1:0] file_wdata_o,
	output logic file_we_o,
	output logic carry_o,
	output logic half_carry_flag_o,
	output logic zero_o,
	output logic flags_we_o,
	output logic [PC_W-1:0] pc_o,
	output logic pc_load_o,
	output logic stack_pop_o,
	output logic [DEPTH_W-1:0] stack_depth_o,
	output logic global_irq_enable_o,
	output logic busy_o,
	output logic done_o
);
	typedef struct packed {
		logic [DATA_W-1:0] work;
		logic [DATA_W-1:0] fwd;
		logic fwe;
		logic c;
		logic dc;
		logic z;
		logic fwe_flags;
		logic [PC_W-1:0] pc;
		logic pc_load;
		logic pop;
		logic [DEPTH_W-1:0] depth;
		logic global_irq_enable;
		logic [1:0] left;
		logic busy;
		logic done;
	} rrs_state_t;

	rrs_state_t s_q, s_d;
	logic [DATA_W-1:0] alu_res;
	logic alu_c, alu_dc, alu_z;
	logic take;

	rrs_alu u_alu (
		.op_i(op_i),
		.src_i(file_data_i),
		.work_i(s_q.work),
		.carry_i(carry_i),
		.res_o(alu_res),
		.carry_o(alu_c),
		.half_o(alu_dc),
		.zero_o(alu_z)
	);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		take = start_i && (s_q.left == 2'h0);
		s_d.fwe = 1'b0;
		s_d.fwe_flags = 1'b0;
		s_d.pc_load = 1'b0;
		s_d.pop = 1'b0;
		s_d.done = 1'b0;
		// Flags pass through untouched unless written below
		s_d.c = carry_i;
		s_d.dc = half_carry_flag_i;
		s_d.z = zero_i;
		if (s_q.left != 2'h0) begin
			s_d.left = s_q.left - 2'h1;
			s_d.done = (s_q.left == 2'h1);
		end
		if (take) begin
			unique case (op_i)
				RRS_OP_RETURN_FROM_SUBROUTINE,
				RRS_OP_RETURN_WITH_LITERAL: begin
					s_d.pc = stack_top_i;
					s_d.pc_load = 1'b1;
					s_d.pop = 1'b1;
					// Depth saturates so an empty pop cannot wrap
					s_d.depth = (stack_depth_i == '0) ? '0
						: stack_depth_i - DEPTH_W'(1);
					s_d.left = RETURN_CYCLES - 2'h1;
					if (op_i == RRS_OP_RETURN_WITH_LITERAL) begin
						s_d.work = literal_i;
						s_d.global_irq_enable = 1'b1;
					end
				end
				RRS_OP_ROTATE_LEFT,
				RRS_OP_ROTATE_RIGHT,
				RRS_OP_SUBTRACT_WITH_BORROW: begin
					s_d.c = alu_c;
					s_d.fwe_flags = 1'b1;
					if (op_i == RRS_OP_SUBTRACT_WITH_BORROW) begin
						s_d.dc = alu_dc;
						s_d.z = alu_z;
					end
					if (dest_sel_i == DEST_FILE) begin
						s_d.fwd = alu_res;
						s_d.fwe = 1'b1;
					end else begin
						s_d.work = alu_res;
					end
					s_d.left = ALU_CYCLES - 2'h1;
					s_d.done = 1'b1;
				end
				default: s_d.done = 1'b1;
			endcase
		end
		// Kept as its own bit so busy_o leaves a flop directly
		s_d.busy = (s_d.left != 2'h0);
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.work <= WORK_RESET;
			s_q.c <= CARRY_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_comb begin
		working_register_o = s_q.work;
		file_wdata_o = s_q.fwd;
		file_we_o = s_q.fwe;
		carry_o = s_q.c;
		half_carry_flag_o = s_q.dc;
		zero_o = s_q.z;
		flags_we_o = s_q.fwe_flags;
		pc_o = s_q.pc;
		pc_load_o = s_q.pc_load;
		stack_pop_o = s_q.pop;
		stack_depth_o = s_q.depth;
		global_irq_enable_o = s_q.global_irq_enable;
		busy_o = s_q.busy;
		done_o = s_q.done;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	ret_busy_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_RETURN_FROM_SUBROUTINE
		|=> busy_o ##1 (!busy_o && done_o))
		else $error("return not two cycles");
	ret_pc_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_RETURN_FROM_SUBROUTINE
		|=> pc_load_o && stack_pop_o && pc_o == $past(stack_top_i)
		&& !flags_we_o)
		else $error("return pc reload wrong");
	rol_res_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_ROTATE_LEFT && dest_sel_i == DEST_WORKING
		|=> working_register_o == {$past(file_data_i[6:0]), $past(carry_i)}
		&& carry_o == $past(file_data_i[7]))
		else $error("rotate left result wrong");
	dest_file_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i != RRS_OP_NONE && op_i != RRS_OP_RETURN_FROM_SUBROUTINE
		&& op_i != RRS_OP_RETURN_WITH_LITERAL && dest_sel_i == DEST_FILE
		|=> file_we_o && $stable(working_register_o))
		else $error("file destination not written");
	rol_flags_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_ROTATE_LEFT
		|=> !busy_o && half_carry_flag_o == $past(half_carry_flag_i)
		&& zero_o == $past(zero_i))
		else $error("rotate left touched other flags");
	ror_res_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_ROTATE_RIGHT && dest_sel_i == DEST_FILE
		|=> file_wdata_o == {$past(carry_i), $past(file_data_i[7:1])}
		&& carry_o == $past(file_data_i[0]))
		else $error("rotate right result wrong");
	ror_flags_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_ROTATE_RIGHT
		|=> !busy_o && zero_o == $past(zero_i))
		else $error("rotate right touched other flags");
	sub_res_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_SUBTRACT_WITH_BORROW
		&& dest_sel_i == DEST_WORKING
		|=> {carry_o, working_register_o} == 9'($past(file_data_i))
		+ 9'($past(~s_q.work)) + 9'($past(carry_i)) && !busy_o)
		else $error("subtract result wrong");
	sub_zero_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		$past(take) && $past(op_i) == RRS_OP_SUBTRACT_WITH_BORROW
		|-> zero_o == ((file_we_o ? file_wdata_o : working_register_o)
		== 8'h00))
		else $error("subtract zero flag wrong");
	lit_ret_a: assert property (
		@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_RETURN_WITH_LITERAL
		|=> working_register_o == $past(literal_i) && global_irq_enable_o
		&& busy_o ##1 !busy_o)
		else $error("literal return wrong");

	cov_ret_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_RETURN_FROM_SUBROUTINE);
	cov_rol_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_ROTATE_LEFT && dest_sel_i == DEST_FILE);
	cov_sub_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_SUBTRACT_WITH_BORROW ##1 zero_o);
	cov_retl_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		take && op_i == RRS_OP_RETURN_WITH_LITERAL);
endmodule
`default_nettype wire

//--- shared/rrs_pkg.sv
// Package: opcodes, widths and timing for the return/rotate/subtract unit
package rrs_pkg;
	localparam int DATA_W = 8;
	localparam int PC_W = 10;
	localparam int DEPTH_W = 3;
	// Operation select codes
	typedef enum logic [2:0] {
		RRS_OP_NONE = 3'b000,
		RRS_OP_RETURN_FROM_SUBROUTINE = 3'b001,
		RRS_OP_RETURN_WITH_LITERAL = 3'b010,
		RRS_OP_ROTATE_LEFT = 3'b011,
		RRS_OP_ROTATE_RIGHT = 3'b100,
		RRS_OP_SUBTRACT_WITH_BORROW = 3'b101
	} rrs_op_t;
	// Destination select values
	localparam logic DEST_WORKING = 1'b0;
	localparam logic DEST_FILE = 1'b1;
	// Instruction cycle counts
	localparam logic [1:0] RETURN_CYCLES = 2'h2;
	localparam logic [1:0] ALU_CYCLES = 2'h1;
	// Half-carry comes out of the low nibble
	localparam int NIBBLE_W = 4;
	// Reset values
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
endpackage

//--- testbench/rrs_exec_tb.sv
// Self-checking bench for the return, rotate and subtract unit
`timescale 1ns/1ps
`default_nettype none
module rrs_exec_tb
	import rrs_pkg::*;
();
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic start_i = 1'b0;
	logic dest_sel_i = 1'b0;
	logic carry_i = 1'b0;
	logic half_carry_flag_i = 1'b0;
	logic zero_i = 1'b0;
	rrs_op_t op_i = RRS_OP_NONE;
	logic [DATA_W-1:0] file_data_i = 8'h00;
	logic [DATA_W-1:0] literal_i = 8'h00;
	logic [PC_W-1:0] stack_top_i = 10'h000;
	logic [DEPTH_W-1:0] stack_depth_i = 3'h0;
	logic [DATA_W-1:0] working_register_o, file_wdata_o;
	logic [PC_W-1:0] pc_o;
	logic [DEPTH_W-1:0] stack_depth_o;
	logic file_we_o, carry_o, half_carry_flag_o, zero_o, flags_we_o;
	logic pc_load_o, stack_pop_o, global_irq_enable_o, busy_o, done_o;
	int fails = 0;
	int total_checks = 0;

	always #4 mclk_i = ~mclk_i;

	rrs_exec i_dut (.mclk_i, .rst_i, .start_i, .op_i, .dest_sel_i,
		.file_data_i, .literal_i, .stack_top_i, .stack_depth_i, .carry_i,
		.half_carry_flag_i, .zero_i, .working_register_o, .file_wdata_o,
		.file_we_o, .carry_o, .half_carry_flag_o, .zero_o, .flags_we_o,
		.pc_o, .pc_load_o, .stack_pop_o, .stack_depth_o,
		.global_irq_enable_o, .busy_o, .done_o);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string s);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, s, seen, exp);
		end
	endtask

	// Drives at one edge, taken at the next, looks just after it
	task issue(input rrs_op_t o, input logic d, input logic [7:0] f,
		input logic c);
		@(posedge mclk_i);
		start_i <= 1'b1;
		op_i <= o;
		dest_sel_i <= d;
		file_data_i <= f;
		literal_i <= f;
		carry_i <= c;
		@(posedge mclk_i);
		start_i <= 1'b0;
		op_i <= RRS_OP_NONE;
		#1;
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task test_return(input logic [2:0] depth, input logic [2:0] exp_depth);
		@(posedge mclk_i);
		stack_top_i <= 10'h2A5;
		stack_depth_i <= depth;
		issue(RRS_OP_RETURN_FROM_SUBROUTINE, 1'b0, 8'h00, 1'b1);
		chk(pc_o, 10'h2A5, "pc");
		chk({pc_load_o, stack_pop_o, busy_o, done_o}, 4'hE, "pulses");
		chk(stack_depth_o, exp_depth, "depth");
		chk({flags_we_o, file_we_o}, 2'h0, "no flag write");
		@(posedge mclk_i);
		#1;
		chk({pc_load_o, busy_o, done_o}, 3'h1, "second cycle");
		$display("return test done");
	endtask

	task load_work(input logic [7:0] v);
		issue(RRS_OP_RETURN_WITH_LITERAL, 1'b0, v, 1'b0);
		chk({pc_load_o, stack_pop_o, busy_o}, 3'h7, "lit return");
		@(posedge mclk_i);
		#1;
		chk(working_register_o, v, "literal");
		chk({global_irq_enable_o, done_o}, 2'h3, "irq enable");
	endtask

	task test_rotate;
		logic [7:0] f, e;
		logic d, c, left, ec;
		for (int i = 0; i < 8; i++) begin
			{left, d, c} = 3'(i);
			f = c ? 8'h3C : 8'hA5;
			e = left ? {f[6:0], c} : {c, f[7:1]};
			ec = left ? f[7] : f[0];
			@(posedge mclk_i);
			half_carry_flag_i <= 1'b1;
			zero_i <= 1'b1;
			issue(left ? RRS_OP_ROTATE_LEFT : RRS_OP_ROTATE_RIGHT, d, f, c);
			chk(d ? file_wdata_o : working_register_o, e, "rot");
			chk(file_we_o, d, "dest");
			chk(carry_o, ec, "rot carry");
			chk({half_carry_flag_o, zero_o}, 2'h3, "flags kept");
			chk({flags_we_o, done_o}, 2'h3, "one cycle");
		end
		$display("rotate test done");
	endtask

	task test_sub(input logic [7:0] w, input logic [7:0] r, input logic c,
		input logic d);
		logic [8:0] s;
		logic [4:0] n;
		s = {1'b0, r} + {1'b0, ~w} + 9'(c);
		n = {1'b0, r[3:0]} + {1'b0, ~w[3:0]} + 5'(c);
		@(posedge mclk_i);
		half_carry_flag_i <= ~n[4];
		zero_i <= ~(s[7:0] == 8'h00);
		load_work(w);
		issue(RRS_OP_SUBTRACT_WITH_BORROW, d, r, c);
		chk(d ? file_wdata_o : working_register_o, s[7:0], "diff");
		chk(d ? working_register_o : 8'h00, d ? w : 8'h00, "work");
		chk(file_we_o, d, "sub dest");
		chk({carry_o, half_carry_flag_o}, {s[8], n[4]}, "sub c dc");
		chk(zero_o, s[7:0] == 8'h00, "sub z");
		chk({flags_we_o, done_o}, 2'h3, "sub cycle");
		$display("subtract test done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		#1;
		chk({working_register_o, global_irq_enable_o}, 9'h000,
			"reset");
		test_return(3'h2, 3'h1);
		test_return(3'h0, 3'h0);
		test_rotate();
		test_sub(8'h06, 8'h05, 1'b0, 1'b1);
		test_sub(8'h06, 8'h05, 1'b1, 1'b1);
		test_sub(8'h05, 8'h06, 1'b0, 1'b1);
		test_sub(8'h05, 8'h06, 1'b1, 1'b1);
		test_sub(8'h10, 8'h10, 1'b1, 1'b0);
		close_out();
	end

	// Whole run is about 72 cycles; this leaves ample margin
	initial begin
		repeat (3000) @(posedge mclk_i);
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		close_out();
	end
endmodule
`default_nettype wire
